// ### pgrs_regs.svh
// register map, bit positions, reset values and timing figures of the rail sequencer
`ifndef PGRS_REGS_SVH
`define PGRS_REGS_SVH

// ==========================================================
// register offsets
`define PGRS_ADDR_GOOD 8'h0b
`define PGRS_ADDR_MASK 8'h0c
`define PGRS_ADDR_CTRL 8'h0d

// ==========================================================
// field positions
`define PGRS_RST_BIT  7
`define PGRS_DLY_HI   6
`define PGRS_DLY_LO   5
`define PGRS_COMB_BIT 5
`define PGRS_SEQ_HI   7
`define PGRS_SEQ_LO   5

// rail positions in status, mask and enable fields
`define PGRS_SDA 4
`define PGRS_SDB 3
`define PGRS_SDC 2
`define PGRS_LRA 1
`define PGRS_LRB 0

// ==========================================================
// reset values
`define PGRS_EN_RESET   5'h1f
`define PGRS_DLY_RESET  2'h3
`define PGRS_MASK_RESET 6'h1c
`define PGRS_SEQ_RESET  3'h0

// ==========================================================
// timing
`define PGRS_CLK_KHZ 200000
`define PGRS_DLY0_MS 20
`define PGRS_DLY1_MS 100
`define PGRS_DLY2_MS 200
`define PGRS_DLY3_MS 400
`define PGRS_GAP_MS  1

`endif

// ### pgrs_pkg.sv
// types shared by the rail sequencer
package pgrs_pkg;

   // ==========================================================
   // sequencer phase
   typedef enum logic [1:0] {
      SEQ_OFF  = 2'b00,
      SEQ_UP   = 2'b01,
      SEQ_ON   = 2'b10,
      SEQ_DOWN = 2'b11
   } pgrs_state_type;

   // ==========================================================
   // power-up order codes
   typedef enum logic [2:0] {
      SQ_B_ONLY     = 3'b000,
      SQ_B_C        = 3'b001,
      SQ_A_THEN_BC  = 3'b010,
      SQ_C_THEN_B   = 3'b011,
      SQ_LB_THEN_AB = 3'b100,
      SQ_PINS       = 3'b101,
      SQ_A_B_C      = 3'b110,
      SQ_EXT_LB_AB  = 3'b111
   } pgrs_code_type;

endpackage : pgrs_pkg

// ### pgrs_sequencer.sv
// power-good combiner, rail enable gating and power-up/down sequencer
`timescale 1ns/10ps
`include "pgrs_regs.svh"

// ==========================================================
// delayed release of an active-low output
module pgrs_release_timer #(
   parameter int CNT_W = 27
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // control
   input  wire logic             hold,
   input  wire logic [CNT_W-1:0] limit,
   // result
   output logic                  released
);

   logic [CNT_W-1:0] count;

   always_ff @(posedge clock) begin
      if (rst || hold) begin
         count    <= '0;
         released <= 1'b0;
      end else if (count >= limit) begin
         released <= 1'b1;
      end else begin
         count <= count + 1'b1;
      end
   end

endmodule : pgrs_release_timer

// ==========================================================
// top level
module pgrs_sequencer #(
   parameter int CNT_W   = 27,
   parameter int DLY0_CYC = `PGRS_DLY0_MS * `PGRS_CLK_KHZ,
   parameter int DLY1_CYC = `PGRS_DLY1_MS * `PGRS_CLK_KHZ,
   parameter int DLY2_CYC = `PGRS_DLY2_MS * `PGRS_CLK_KHZ,
   parameter int DLY3_CYC = `PGRS_DLY3_MS * `PGRS_CLK_KHZ,
   // strictly more than the gap
   parameter int GAP_CYC  = `PGRS_GAP_MS * `PGRS_CLK_KHZ + 1
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // register port
   input  wire logic [7:0] regAddr,
   input  wire logic       regWrite,
   input  wire logic [7:0] regWrData,
   input  wire logic       regRead,
   output logic      [7:0] regRdData,
   // rail status
   input  wire logic [4:0] railGood,
   input  wire logic       resetCompBelow,
   // enable pins and device state
   input  wire logic       stepDownAEnablePin,
   input  wire logic       stepDownBEnablePin,
   input  wire logic       stepDownCEnablePin,
   input  wire logic       linearRegEnableSignal,
   input  wire logic       stepDownCPinOverride,
   input  wire logic       onState,
   // rail controls
   output logic      [4:0] railEnable,
   output logic            extRegulatorEnable,
   // open-drain power good and driven reset output
   output logic            powerGoodOutOut,
   output logic            powerGoodOutEn,
   output logic            resetOutN
);

   // ==========================================================
   // registers
   logic [1:0]             goodOutputDelay;
   logic [5:0]             goodMask;
   pgrs_pkg::pgrs_code_type sequenceSelect;
   logic [4:0]             supplyEnable;
   logic [4:0]             enablePins;

   localparam logic [4:0] EN_DEFAULT = `PGRS_EN_RESET;

   assign enablePins = {stepDownAEnablePin,
                        stepDownBEnablePin,
                        stepDownCEnablePin,
                        linearRegEnableSignal,
                        linearRegEnableSignal};

   always_ff @(posedge clock) begin
      if (rst) begin
         goodOutputDelay <= `PGRS_DLY_RESET;
      end else if (regWrite && regAddr == `PGRS_ADDR_GOOD) begin
         goodOutputDelay <= regWrData[`PGRS_DLY_HI:`PGRS_DLY_LO];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         goodMask <= `PGRS_MASK_RESET;
      end else if (regWrite && regAddr == `PGRS_ADDR_MASK) begin
         goodMask <= regWrData[5:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sequenceSelect <= pgrs_pkg::pgrs_code_type'(`PGRS_SEQ_RESET);
      end else if (regWrite && regAddr == `PGRS_ADDR_CTRL) begin
         sequenceSelect <= pgrs_pkg::pgrs_code_type'(regWrData[`PGRS_SEQ_HI:`PGRS_SEQ_LO]);
      end
   end

   // a low pin wins over a write in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         supplyEnable <= `PGRS_EN_RESET;
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (!enablePins[i]) begin
               supplyEnable[i] <= EN_DEFAULT[i];
            end else if (regWrite && regAddr == `PGRS_ADDR_CTRL) begin
               supplyEnable[i] <= regWrData[i];
            end
         end
      end
   end

   // read data registered; unmapped offsets read zero
   always_ff @(posedge clock) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            `PGRS_ADDR_GOOD: begin
               regRdData <= {resetCompBelow,
                             goodOutputDelay,
                             railGood};
            end
            `PGRS_ADDR_MASK: begin
               regRdData <= {2'h0, goodMask};
            end
            `PGRS_ADDR_CTRL: begin
               regRdData <= {sequenceSelect, supplyEnable};
            end
            default: begin
               regRdData <= 8'h00;
            end
         endcase
      end
   end

   // ==========================================================
   // power good and reset output
   logic             goodFault;
   logic [CNT_W-1:0] delayLimit;
   logic             goodReleased;

   always_comb begin
      goodFault = |(goodMask[4:0] & ~railGood);
      if (goodMask[`PGRS_COMB_BIT] &&
          !railGood[`PGRS_SDC] && !railGood[`PGRS_LRA]) begin
         goodFault = 1'b1;
      end
   end

   always_comb begin
      case (goodOutputDelay)
         2'h0: delayLimit = CNT_W'(DLY0_CYC);
         2'h1: delayLimit = CNT_W'(DLY1_CYC);
         2'h2: delayLimit = CNT_W'(DLY2_CYC);
         default: delayLimit = CNT_W'(DLY3_CYC);
      endcase
   end

   pgrs_release_timer #(.CNT_W(CNT_W)) goodTimer (
      .clock    (clock),
      .rst      (rst),
      .hold     (goodFault),
      .limit    (delayLimit),
      .released (goodReleased)
   );

   pgrs_release_timer #(.CNT_W(CNT_W)) resetTimer (
      .clock    (clock),
      .rst      (rst),
      .hold     (resetCompBelow),
      .limit    (delayLimit),
      .released (resetOutN)
   );

   // open drain: only ever pulls low
   assign powerGoodOutOut = 1'b0;
   assign powerGoodOutEn  = !goodReleased || goodFault;

   // ==========================================================
   // sequencer
   pgrs_pkg::pgrs_state_type state;
   pgrs_pkg::pgrs_code_type  activeCode;
   logic [1:0]               stage;
   logic [31:0]              gapCount;

   // rails switched on by the order up to a stage
   function automatic logic [4:0] autoRails(
      input pgrs_pkg::pgrs_code_type code,
      input logic [1:0]              stg,
      input logic                    ovr
   );
      logic [4:0] r;
      r = 5'h00;
      if (stg != 2'h0) begin
         case (code)
            pgrs_pkg::SQ_B_ONLY: r[`PGRS_SDB] = 1'b1;
            pgrs_pkg::SQ_B_C: begin
               r[`PGRS_SDB] = 1'b1;
               r[`PGRS_SDC] = 1'b1;
            end
            pgrs_pkg::SQ_A_THEN_BC: begin
               r[`PGRS_SDA] = 1'b1;
               r[`PGRS_SDB] = stg >= 2'h2;
               r[`PGRS_SDC] = stg >= 2'h2;
            end
            pgrs_pkg::SQ_C_THEN_B: begin
               r[`PGRS_SDC] = 1'b1;
               r[`PGRS_SDB] = stg >= 2'h2;
            end
            pgrs_pkg::SQ_LB_THEN_AB: begin
               r[`PGRS_LRB] = 1'b1;
               r[`PGRS_SDC] = ovr;
               r[`PGRS_SDA] = stg >= 2'h2;
               r[`PGRS_SDB] = stg >= 2'h2;
            end
            pgrs_pkg::SQ_A_B_C: begin
               r[`PGRS_SDA] = 1'b1;
               r[`PGRS_SDB] = stg >= 2'h2;
               r[`PGRS_SDC] = stg >= 2'h3;
            end
            pgrs_pkg::SQ_EXT_LB_AB: begin
               r[`PGRS_LRB] = stg >= 2'h2;
               r[`PGRS_SDA] = stg >= 2'h3;
               r[`PGRS_SDB] = stg >= 2'h3;
            end
            default: r = 5'h00;
         endcase
      end
      return r;
   endfunction : autoRails

   logic [1:0] lastStage;
   logic [4:0] stageRails;
   logic [4:0] waitRails;
   logic [4:0] droppedRails;
   logic       upAdvance;

   always_comb begin
      case (activeCode)
         pgrs_pkg::SQ_B_ONLY, pgrs_pkg::SQ_B_C: lastStage = 2'h1;
         pgrs_pkg::SQ_A_B_C, pgrs_pkg::SQ_EXT_LB_AB: lastStage = 2'h3;
         default: lastStage = 2'h2;
      endcase
   end

   assign stageRails = autoRails(activeCode, stage, stepDownCPinOverride);
   assign droppedRails = autoRails(activeCode, stage + 2'h1, stepDownCPinOverride)
                         & ~stageRails;

   // the next group waits for the previous group to report good; code 100 waits on LRB alone, code 111 on the gap count
   always_comb begin
      waitRails = stageRails;
      if (activeCode == pgrs_pkg::SQ_LB_THEN_AB) begin
         waitRails = 5'h01 << `PGRS_LRB;
      end
      upAdvance = (waitRails & ~railGood) == 5'h00;
      if (activeCode == pgrs_pkg::SQ_EXT_LB_AB && stage == 2'h2) begin
         upAdvance = gapCount >= GAP_CYC;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || state != pgrs_pkg::SEQ_UP || stage != 2'h2) begin
         gapCount <= 32'h0;
      end else if (gapCount < GAP_CYC) begin
         gapCount <= gapCount + 32'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state      <= pgrs_pkg::SEQ_OFF;
         stage      <= 2'h0;
         activeCode <= pgrs_pkg::SQ_PINS;
      end else begin
         case (state)
            pgrs_pkg::SEQ_OFF: begin
               if (onState && sequenceSelect != pgrs_pkg::SQ_PINS) begin
                  state      <= pgrs_pkg::SEQ_UP;
                  stage      <= 2'h1;
                  activeCode <= sequenceSelect;
               end
            end
            pgrs_pkg::SEQ_UP: begin
               if (!onState) begin
                  state <= pgrs_pkg::SEQ_DOWN;
                  stage <= stage - 2'h1;
               end else if (upAdvance) begin
                  if (stage == lastStage) begin
                     state <= pgrs_pkg::SEQ_ON;
                  end else begin
                     stage <= stage + 2'h1;
                  end
               end
            end
            pgrs_pkg::SEQ_ON: begin
               if (!onState) begin
                  state <= pgrs_pkg::SEQ_DOWN;
                  stage <= stage - 2'h1;
               end
            end
            pgrs_pkg::SEQ_DOWN: begin
               // last group must fall before the one below it drops
               if ((droppedRails & railGood) == 5'h00) begin
                  if (stage == 2'h0) begin
                     state <= pgrs_pkg::SEQ_OFF;
                  end else begin
                     stage <= stage - 2'h1;
                  end
               end
            end
            default: state <= pgrs_pkg::SEQ_OFF;
         endcase
      end
   end

   // ==========================================================
   // rail outputs
   always_ff @(posedge clock) begin
      if (rst) begin
         railEnable         <= 5'h00;
         extRegulatorEnable <= 1'b0;
      end else begin
         // pins of rails in the order are tied low; the order stands in
         railEnable <= supplyEnable & (stageRails | enablePins);
         extRegulatorEnable <= activeCode == pgrs_pkg::SQ_EXT_LB_AB &&
                               stage != 2'h0;
      end
   end

   // ==========================================================
   // checks
   property p_status_reset;
      @(posedge clock) disable iff (rst)
      (regRead && regAddr == `PGRS_ADDR_GOOD) |=>
         regRdData[`PGRS_RST_BIT] == $past(resetCompBelow);
   endproperty
   a_status_reset: assert property (p_status_reset)
      else $error("reset status bit wrong");

   property p_status_rails;
      @(posedge clock) disable iff (rst)
      (regRead && regAddr == `PGRS_ADDR_GOOD) |=> regRdData[4:0] == $past(railGood);
   endproperty
   a_status_rails: assert property (p_status_rails)
      else $error("rail status bits wrong");

   property p_delay_write;
      @(posedge clock) disable iff (rst)
      (regWrite && regAddr == `PGRS_ADDR_GOOD) |=>
         goodOutputDelay == $past(regWrData[`PGRS_DLY_HI:`PGRS_DLY_LO]);
   endproperty
   a_delay_write: assert property (p_delay_write)
      else $error("delay field not written");

   property p_mask_fault;
      @(posedge clock) disable iff (rst)
      |(goodMask[4:0] & ~railGood) |-> powerGoodOutEn;
   endproperty
   a_mask_fault: assert property (p_mask_fault)
      else $error("masked rail fault did not pull power good");

   property p_comb_fault;
      @(posedge clock) disable iff (rst)
      (goodMask[`PGRS_COMB_BIT] && !railGood[`PGRS_SDC] && !railGood[`PGRS_LRA])
         |-> powerGoodOutEn;
   endproperty
   a_comb_fault: assert property (p_comb_fault)
      else $error("combined fault did not pull power good");

   property p_release_after_delay;
      @(posedge clock) disable iff (rst)
      $fell(powerGoodOutEn) |-> !$past(goodFault, 2) && !goodFault;
   endproperty
   a_release_after_delay: assert property (p_release_after_delay)
      else $error("power good released during fault");

   property p_pin_low_default;
      @(posedge clock) disable iff (rst)
      !stepDownAEnablePin |=> supplyEnable[`PGRS_SDA];
   endproperty
   a_pin_low_default: assert property (p_pin_low_default)
      else $error("enable bit not forced while pin low");

   property p_enable_gated;
      @(posedge clock) disable iff (rst)
      railEnable[`PGRS_SDB] |-> $past(supplyEnable[`PGRS_SDB]);
   endproperty
   a_enable_gated: assert property (p_enable_gated)
      else $error("rail enabled with enable bit clear");

   property p_a_before_bc;
      @(posedge clock) disable iff (rst)
      (state == pgrs_pkg::SEQ_UP && activeCode == pgrs_pkg::SQ_A_THEN_BC &&
       $changed(stage) && stage == 2'h2) |-> $past(railGood[`PGRS_SDA]);
   endproperty
   a_a_before_bc: assert property (p_a_before_bc)
      else $error("converters B and C started before A good");

   property p_ext_first;
      @(posedge clock) disable iff (rst)
      (state == pgrs_pkg::SEQ_UP && activeCode == pgrs_pkg::SQ_EXT_LB_AB &&
       stage == 2'h2) |=> extRegulatorEnable;
   endproperty
   a_ext_first: assert property (p_ext_first)
      else $error("external regulator not enabled first");

endmodule : pgrs_sequencer

// ### pgrs_rail_model.sv
// behavioural rails: good after a settling time, bad on the next clock edge when disabled
`timescale 1ns/10ps

// ==========================================================
// rail model
module pgrs_rail_model #(
   parameter int LAT = 4
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // rail controls and injected faults
   input  wire logic [4:0] railEnable,
   input  wire logic [4:0] failMask,
   // rail status
   output logic      [4:0] railGood
);
   logic [2:0] cnt [5];

   // settle counter; a disabled rail stops reporting good at the next clock edge
   always_ff @(posedge clock) begin
      for (int i = 0; i < 5; i++) begin
         if (rst || !railEnable[i]) begin
            cnt[i] <= 3'h0;
         end else if (cnt[i] != LAT[2:0]) begin
            cnt[i] <= cnt[i] + 3'h1;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 5; i++) begin
         railGood[i] = (cnt[i] == LAT[2:0]) && !failMask[i];
      end
   end
endmodule : pgrs_rail_model

// ### tb.sv
// register-level bench of the rail sequencer
`timescale 1ns/10ps
`include "pgrs_regs.svh"

module tb;
   localparam int GAP = 11;
   logic        clock, rst, regWrite, regRead, resetCompBelow, onState;
   logic        pinA, pinB, pinC, pinL, ovr, extRegulatorEnable;
   logic        powerGoodOutOut, powerGoodOutEn, resetOutN;
   logic [7:0]  regAddr, regWrData, regRdData;
   logic [4:0]  railGood, railEnable, failMask;
   logic [4:0]  seqTab [8][3];
   int          seqN [8];
   int          num_errors, n_compared;

   pgrs_sequencer #(.DLY0_CYC(20), .DLY1_CYC(100), .DLY2_CYC(200), .DLY3_CYC(400),
      .GAP_CYC(GAP)) i_dut (
      .clock(clock), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
      .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
      .railGood(railGood), .resetCompBelow(resetCompBelow),
      .stepDownAEnablePin(pinA), .stepDownBEnablePin(pinB), .stepDownCEnablePin(pinC),
      .linearRegEnableSignal(pinL), .stepDownCPinOverride(ovr), .onState(onState),
      .railEnable(railEnable), .extRegulatorEnable(extRegulatorEnable),
      .powerGoodOutOut(powerGoodOutOut), .powerGoodOutEn(powerGoodOutEn),
      .resetOutN(resetOutN));

   pgrs_rail_model #(.LAT(4)) i_rails (
      .clock(clock), .rst(rst), .railEnable(railEnable), .failMask(failMask),
      .railGood(railGood));

   // ==========================================================
   // helpers
   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_cyc

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask : reg_write

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      chk({8'h00, regRdData}, {8'h00, exp}, "register read");
   endtask : rd_chk

   // ==========================================================
   // one power-up and power-down cycle with all pins low
   task automatic run_code(input logic [2:0] code);
      logic [14:0] obs, expUp, expDn;
      logic [4:0]  last;
      int          tLb, tAb;
      obs = '0;
      last = '0;
      expUp = '0;
      expDn = '0;
      tLb = 0;
      tAb = 0;
      for (int i = 0; i < seqN[code]; i++) expUp = {expUp[9:0], seqTab[code][i]};
      for (int i = seqN[code] - 2; i >= 0; i--) expDn = {expDn[9:0], seqTab[code][i]};
      if (seqN[code] > 0) expDn = {expDn[9:0], 5'h00};
      reg_write(`PGRS_ADDR_CTRL, {code, 5'h1f});
      wait_cyc(10);
      chk({11'h0, railEnable}, 16'h0, "start before on");
      @(posedge clock) onState <= 1'b1;
      for (int c = 0; c < 80; c++) begin
         @(posedge clock);
         #1;
         if (railEnable !== last) begin
            if (railEnable[0] && !last[0]) begin
               tLb = c;
               chk({15'h0, extRegulatorEnable}, {15'h0, code == 3'h7}, "ext enable");
            end
            if (railEnable[4] && !last[4]) tAb = c;
            obs = {obs[9:0], railEnable};
            last = railEnable;
         end
      end
      chk({1'b0, obs}, {1'b0, expUp}, "power-up order");
      if (code == 3'h7) chk({15'h0, (tAb - tLb) >= GAP}, 16'h1, "gap too short");
      @(posedge clock) onState <= 1'b0;
      obs = '0;
      for (int c = 0; c < 80; c++) begin
         @(posedge clock);
         #1;
         if (railEnable !== last) begin
            obs = {obs[9:0], railEnable};
            last = railEnable;
         end
      end
      chk({1'b0, obs}, {1'b0, expDn}, "power-down order");
   endtask : run_code

   // ==========================================================
   // fault, then timed release of power good
   task automatic pg_delay(input logic [1:0] d, input int lim);
      int n;
      n = 0;
      reg_write(`PGRS_ADDR_GOOD, {1'b0, d, 5'h00});
      @(posedge clock) failMask <= 5'h04;
      wait_cyc(2);
      chk({14'h0, powerGoodOutEn, powerGoodOutOut}, 16'h2, "fault not driven");
      @(posedge clock) failMask <= 5'h00;
      #1;
      while (powerGoodOutEn !== 1'b0) begin
         @(posedge clock);
         #1;
         n++;
         if (n > lim + 8) begin
            num_errors++;
            $display("ERROR %0t power good never released", $time);
            end_sim();
         end
      end
      chk({15'h0, n >= lim}, 16'h1, "released early");
      rd_chk(`PGRS_ADDR_GOOD, {1'b0, d, 5'h1f});
   endtask : pg_delay

   // ==========================================================
   // clock, reset, sequence
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial begin
      seqTab = '{'{5'h08, 5'h00, 5'h00}, '{5'h0c, 5'h00, 5'h00}, '{5'h10, 5'h1c, 5'h00},
                 '{5'h04, 5'h0c, 5'h00}, '{5'h05, 5'h1d, 5'h00}, '{5'h00, 5'h00, 5'h00},
                 '{5'h10, 5'h18, 5'h1c}, '{5'h01, 5'h19, 5'h00}};
      seqN = '{1, 1, 2, 2, 2, 0, 3, 2};
      num_errors = 0;
      n_compared = 0;
      rst = 1'b1;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      resetCompBelow = 1'b1;
      onState = 1'b0;
      {pinA, pinB, pinC, pinL} = 4'h0;
      ovr = 1'b1;
      failMask = 5'h00;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      wait_cyc(1);
      chk({13'h0, powerGoodOutEn, resetOutN, powerGoodOutOut}, 16'h4, "outputs after reset");
      rd_chk(`PGRS_ADDR_GOOD, 8'he0);
      rd_chk(`PGRS_ADDR_MASK, 8'h1c);
      rd_chk(`PGRS_ADDR_CTRL, 8'h1f);
      rd_chk(8'h0e, 8'h00);
      @(posedge clock) resetCompBelow <= 1'b0;
      rd_chk(`PGRS_ADDR_GOOD, 8'h60);
      // enable bits snap back while pins are low
      reg_write(`PGRS_ADDR_CTRL, 8'he3);
      rd_chk(`PGRS_ADDR_CTRL, 8'hff);
      @(posedge clock) pinA <= 1'b1;
      reg_write(`PGRS_ADDR_CTRL, 8'h0f);
      rd_chk(`PGRS_ADDR_CTRL, 8'h0f);
      @(posedge clock) pinA <= 1'b0;
      rd_chk(`PGRS_ADDR_CTRL, 8'h1f);
      for (int k = 0; k < 8; k++) begin
         if (k != 5) run_code(k[2:0]);
      end
      // override clear: converter C stays with its low pin in code 100
      @(posedge clock) ovr <= 1'b0;
      seqTab[4] = '{5'h01, 5'h19, 5'h00};
      run_code(3'h4);
      // pin-only mode
      reg_write(`PGRS_ADDR_CTRL, 8'hbf);
      @(posedge clock) onState <= 1'b1;
      wait_cyc(20);
      chk({11'h0, railEnable}, 16'h0, "auto start in pin mode");
      @(posedge clock) {pinA, pinB, pinC} <= 3'h7;
      wait_cyc(3);
      chk({11'h0, railEnable}, 16'h1c, "pin enable");
      reg_write(`PGRS_ADDR_CTRL, 8'haf);
      wait_cyc(3);
      chk({11'h0, railEnable}, 16'h0c, "enable bit gating");
      @(posedge clock) onState <= 1'b0;
      {pinA, pinB, pinC} <= 3'h0;
      wait_cyc(20);
      // power good combiner on a running system
      reg_write(`PGRS_ADDR_CTRL, 8'hdf);
      @(posedge clock) pinL <= 1'b1;
      onState <= 1'b1;
      wait_cyc(40);
      rd_chk(`PGRS_ADDR_GOOD, 8'h7f);
      pg_delay(2'h0, 20);
      pg_delay(2'h1, 100);
      pg_delay(2'h2, 200);
      pg_delay(2'h3, 400);
      chk({15'h0, resetOutN}, 16'h1, "reset output held");
      reg_write(`PGRS_ADDR_GOOD, 8'h00);
      reg_write(`PGRS_ADDR_MASK, 8'h18);
      @(posedge clock) failMask <= 5'h04;
      wait_cyc(3);
      chk({15'h0, powerGoodOutEn}, 16'h0, "masked rail");
      rd_chk(`PGRS_ADDR_GOOD, 8'h1b);
      reg_write(`PGRS_ADDR_MASK, 8'h20);
      wait_cyc(3);
      chk({15'h0, powerGoodOutEn}, 16'h0, "combined, one bad");
      @(posedge clock) failMask <= 5'h06;
      wait_cyc(2);
      chk({15'h0, powerGoodOutEn}, 16'h1, "combined, both bad");
      reg_write(`PGRS_ADDR_MASK, 8'hff);
      rd_chk(`PGRS_ADDR_MASK, 8'h3f);
      end_sim();
   end
endmodule : tb
